/* File: apmc_pkg.sv */
/*
  Shared constants and types for the accelerometer power-mode controller:
  register offsets, field positions, reset values, rate codes, timing.
  Assumes a 50 MHz core clock and a serial slave front end outside.
*/
package apmc_pkg;

  // Register offsets
  localparam logic [5:0] APMC_ADDR_INACT_THRESH = 6'h25;
  localparam logic [5:0] APMC_ADDR_INACT_TIME = 6'h26;
  localparam logic [5:0] APMC_ADDR_DATA_RATE = 6'h2C;
  localparam logic [5:0] APMC_ADDR_POWER = 6'h2D;

  // Field positions
  localparam int APMC_PC_MEASURE = 3;
  localparam int APMC_PC_AUTO_SLEEP = 4;
  localparam int APMC_PC_LINK = 5;
  localparam int APMC_DR_LOW_POWER = 4;

  // Reset values
  localparam logic [7:0] APMC_RST_DATA_RATE = 8'h0A;
  localparam logic [7:0] APMC_RST_POWER = 8'h00;
  localparam logic [7:0] APMC_RST_INACT = 8'h00;
  localparam logic [7:0] APMC_RD_ZERO = 8'h00;

  // Rate codes
  localparam logic [3:0] APMC_RATE_MAX = 4'hF;
  localparam logic [3:0] APMC_RATE_MIN = 4'h6;
  localparam logic [3:0] APMC_RATE_LP_LO = 4'h7;
  localparam logic [3:0] APMC_RATE_LP_HI = 4'hC;
  localparam logic [3:0] APMC_RATE_SLEEP = 4'h6;

  // Timing
  localparam int APMC_CLK_MHZ = 50;
  localparam int APMC_FAST_ODR_HZ = 3200;
  localparam int APMC_T_WAKE_EXTRA_US = 1100;
  localparam int APMC_WAKE_EXTRA_CYC = APMC_T_WAKE_EXTRA_US * APMC_CLK_MHZ;
  localparam int APMC_FAST_PERIOD_CYC = (APMC_CLK_MHZ * 1_000_000) / APMC_FAST_ODR_HZ;
  localparam int APMC_CNT_W = 24;

  typedef enum logic [1:0] {APMC_STANDBY, APMC_WAKE, APMC_MEASURE, APMC_SLEEP} apmc_state_t;

  // One completed byte access from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] data;
  } apmc_req_t;

  typedef struct packed {
    logic measuring;
    logic waking;
    logic asleep;
    logic low_power_active;
    logic [3:0] eff_rate;
  } apmc_status_t;

endpackage

/* File: apmc_ticker.sv */
/*
  Sample-period divider: one-cycle tick every 'period' core clocks while run.
  Assumes period is at least 2 and held stable between restarts.
*/
`timescale 1ns/1ps
module apmc_ticker
  import apmc_pkg::*;
#(
  parameter int CNT_W = APMC_CNT_W
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic [CNT_W-1:0] period,
  // Event
  output logic tick_r
);

  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge core_clk)
  begin
    if (rst || !run || restart)
    begin
      cnt_r <= '0;
    end
    else if (cnt_r >= period - CNT_W'(1))
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || !run || restart)
    begin
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (cnt_r >= period - CNT_W'(1));
    end
  end

endmodule

/* File: apmc_core.sv */
/*
  Power-mode controller: standby, wake-up, measurement and auto-sleep,
  with its four control registers behind the serial slave's byte port.
  Assumes the front end pulses req.wr only after a full data byte and
  that the inactivity detector runs on core_clk.
*/
`timescale 1ns/1ps

// Function
// - Power-up lands in standby, sensing off
// - Measure bit enters measurement, clearing returns standby
// - All registers accessible while in standby
// - No samples taken while in standby
// - Standby keeps stored samples, no flush
// - Four-bit code selects output data rate
// - Low power bit reduces internal sampling (here only flagged for rate codes 7 to C, in measurement)
// - Auto-sleep drops below 8 Hz when inactive
// - First data after period plus 1.1 ms
module apmc_core
  import apmc_pkg::*;
#(
  parameter int CNT_W = APMC_CNT_W,
  parameter int FAST_PERIOD_CYC = APMC_FAST_PERIOD_CYC,
  parameter int WAKE_EXTRA_CYC = APMC_WAKE_EXTRA_CYC
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Byte port from serial slave
  input wire apmc_req_t req,
  output logic [7:0] reg_rdata_r,
  output logic reg_rvalid_r,
  // Inactivity detector
  input wire logic inactive,
  output logic [7:0] inact_thresh_r,
  output logic [7:0] inact_time_r,
  // Sensing datapath
  output logic sample_tick,
  output logic first_data_r,
  output apmc_status_t status_r
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] rate_ctl_r;
  logic [7:0] power_control_r;
  apmc_state_t state_r;
  apmc_state_t state_nxt;
  logic [CNT_W-1:0] wake_cnt_r;
  logic [3:0] eff_rate;
  logic [CNT_W-1:0] period;
  logic lp_nxt;
  logic measure;
  logic sleep_ok;

  // Codes below the slowest documented rate run at that rate
  function automatic logic [3:0] clamp_rate(input logic [3:0] code);
    clamp_rate = (code < APMC_RATE_MIN) ? APMC_RATE_MIN : code;
  endfunction

  // Each code step down doubles the period of the fastest rate
  function automatic logic [CNT_W-1:0] period_of(input logic [3:0] code);
    logic [3:0] sh;
    sh = APMC_RATE_MAX - clamp_rate(code);
    period_of = CNT_W'(FAST_PERIOD_CYC) << sh;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, applied on the completed-byte strobe only
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      inact_thresh_r <= APMC_RST_INACT;
      inact_time_r <= APMC_RST_INACT;
      rate_ctl_r <= APMC_RST_DATA_RATE;
      power_control_r <= APMC_RST_POWER;
    end
    else if (req.wr)
    begin
      if (req.addr == APMC_ADDR_INACT_THRESH)
      begin
        inact_thresh_r <= req.data;
      end
      else if (req.addr == APMC_ADDR_INACT_TIME)
      begin
        inact_time_r <= req.data;
      end
      else if (req.addr == APMC_ADDR_DATA_RATE)
      begin
        rate_ctl_r <= req.data;
      end
      else if (req.addr == APMC_ADDR_POWER)
      begin
        power_control_r <= req.data;
      end
    end
  end

  // Reads answer in any mode; unmapped addresses read zero
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      reg_rdata_r <= APMC_RD_ZERO;
      reg_rvalid_r <= 1'b0;
    end
    else
    begin
      reg_rvalid_r <= req.rd;
      if (!req.rd)
      begin
        reg_rdata_r <= reg_rdata_r;
      end
      else if (req.addr == APMC_ADDR_INACT_THRESH)
      begin
        reg_rdata_r <= inact_thresh_r;
      end
      else if (req.addr == APMC_ADDR_INACT_TIME)
      begin
        reg_rdata_r <= inact_time_r;
      end
      else if (req.addr == APMC_ADDR_DATA_RATE)
      begin
        reg_rdata_r <= rate_ctl_r;
      end
      else if (req.addr == APMC_ADDR_POWER)
      begin
        reg_rdata_r <= power_control_r;
      end
      else
      begin
        reg_rdata_r <= APMC_RD_ZERO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign measure = power_control_r[APMC_PC_MEASURE];
  assign sleep_ok = power_control_r[APMC_PC_AUTO_SLEEP] && power_control_r[APMC_PC_LINK];
  assign eff_rate = (state_r == APMC_SLEEP) ? APMC_RATE_SLEEP : clamp_rate(rate_ctl_r[3:0]);
  assign period = period_of(eff_rate);
  // Reduced internal sampling only pays off inside this band
  assign lp_nxt = rate_ctl_r[APMC_DR_LOW_POWER] && (eff_rate >= APMC_RATE_LP_LO)
    && (eff_rate <= APMC_RATE_LP_HI) && (state_r == APMC_MEASURE);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      APMC_STANDBY:
      begin
        if (measure)
        begin
          state_nxt = APMC_WAKE;
        end
      end
      APMC_WAKE:
      begin
        if (!measure)
        begin
          state_nxt = APMC_STANDBY;
        end
        else if (wake_cnt_r == '0)
        begin
          state_nxt = APMC_MEASURE;
        end
      end
      APMC_MEASURE:
      begin
        if (!measure)
        begin
          state_nxt = APMC_STANDBY;
        end
        else if (sleep_ok && inactive)
        begin
          state_nxt = APMC_SLEEP;
        end
      end
      default:
      begin
        if (!measure)
        begin
          state_nxt = APMC_STANDBY;
        end
        else if (!inactive || !sleep_ok)
        begin
          state_nxt = APMC_WAKE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_r <= APMC_STANDBY;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Turn-on and wake-up settle: one output period plus fixed overhead
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wake_cnt_r <= '0;
      first_data_r <= 1'b0;
    end
    else
    begin
      first_data_r <= (state_r == APMC_WAKE) && (state_nxt == APMC_MEASURE);
      if (state_r != APMC_WAKE && state_nxt == APMC_WAKE)
      begin
        wake_cnt_r <= period_of(rate_ctl_r[3:0]) + CNT_W'(WAKE_EXTRA_CYC);
      end
      else if (state_r == APMC_WAKE && wake_cnt_r != '0)
      begin
        wake_cnt_r <= wake_cnt_r - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      status_r <= '0;
    end
    else
    begin
      status_r.measuring <= (state_nxt == APMC_MEASURE);
      status_r.waking <= (state_nxt == APMC_WAKE);
      status_r.asleep <= (state_nxt == APMC_SLEEP);
      status_r.low_power_active <= lp_nxt;
      status_r.eff_rate <= eff_rate;
    end
  end

  // Standby only stops the tick; buffered samples are never flushed here
  apmc_ticker #(
    .CNT_W(CNT_W)
  ) u_ticker (
    .core_clk(core_clk),
    .rst(rst),
    .run((state_r == APMC_MEASURE) || (state_r == APMC_SLEEP)),
    .restart(state_r != state_nxt),
    .period(period),
    .tick_r(sample_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_wake_end;
    (state_r == APMC_WAKE) && measure && (wake_cnt_r == '0);
  endsequence

  property p_reset_standby;
    disable iff (1'b0) rst |=> (state_r == APMC_STANDBY) && !status_r.measuring;
  endproperty
  a_reset_standby: assert property (p_reset_standby) else $error("not standby after reset");

  property p_clear_to_standby;
    (state_r != APMC_STANDBY) && !measure |=> (state_r == APMC_STANDBY);
  endproperty
  a_clear_to_standby: assert property (p_clear_to_standby) else $error("no return to standby");

  property p_measure_wakes;
    (state_r == APMC_STANDBY) && measure |=> (state_r == APMC_WAKE) && status_r.waking;
  endproperty
  a_measure_wakes: assert property (p_measure_wakes) else $error("measure did not wake");

  property p_standby_read;
    (state_r == APMC_STANDBY) && req.rd |=> reg_rvalid_r;
  endproperty
  a_standby_read: assert property (p_standby_read) else $error("standby read lost");

  property p_no_tick_standby;
    (state_r == APMC_STANDBY) [*2] |-> !sample_tick;
  endproperty
  a_no_tick_standby: assert property (p_no_tick_standby) else $error("tick in standby");

  property p_power_write;
    req.wr && (req.addr == APMC_ADDR_POWER) |=> (power_control_r == $past(req.data));
  endproperty
  a_power_write: assert property (p_power_write) else $error("power write not applied");

  property p_lp_flag;
    status_r.low_power_active |-> $past(rate_ctl_r[APMC_DR_LOW_POWER])
      && ($past(state_r) == APMC_MEASURE);
  endproperty
  a_lp_flag: assert property (p_lp_flag) else $error("low power flag without cause");

  property p_sleep_rate;
    status_r.asleep && $past(status_r.asleep) |-> (status_r.eff_rate == APMC_RATE_SLEEP);
  endproperty
  a_sleep_rate: assert property (p_sleep_rate) else $error("sleep rate not slow");

  property p_sleep_entry;
    (state_r == APMC_MEASURE) && measure && sleep_ok && inactive |=> (state_r == APMC_SLEEP);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("auto sleep missed");

  property p_wake_done;
    s_wake_end |=> (state_r == APMC_MEASURE) && first_data_r;
  endproperty
  a_wake_done: assert property (p_wake_done) else $error("wake end not signalled");

  property p_fast_period;
    (eff_rate == APMC_RATE_MAX) |-> (period == CNT_W'(FAST_PERIOD_CYC));
  endproperty
  a_fast_period: assert property (p_fast_period) else $error("fast period wrong");

endmodule

/* File: apmc_host_model.sv */
/*
  Host-side model: issues single-byte register accesses on the byte port.
  Assumes apmc_core answers reads within a few cycles.
*/
`timescale 1ns/1ps
module apmc_host_model
  import apmc_pkg::*;
(
  // Clock
  core_clk,
  // Byte port
  req,
  reg_rdata_r,
  reg_rvalid_r
);
  input wire logic core_clk;
  output apmc_req_t req;
  input wire logic [7:0] reg_rdata_r;
  input wire logic reg_rvalid_r;

  initial req = '0;

  // Whole bytes only; released lines show inverted values, not stale ones
  task automatic put(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req <= '{wr: w, rd: r, addr: a, data: d};
    @(negedge core_clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
  endtask

  task automatic write_byte(input logic [5:0] a, input logic [7:0] d);
    put(1'b1, 1'b0, a, d);
  endtask

  task automatic read_byte(input logic [5:0] a, output logic [7:0] d);
    int i;
    i = 0;
    put(1'b0, 1'b1, a, 8'h00);
    while (reg_rvalid_r !== 1'b1 && i < 4)
    begin
      @(negedge core_clk);
      i++;
    end
    d = (i < 4) ? reg_rdata_r : 8'hxx;
  endtask
endmodule

/* File: test_accel_power_mode_control.sv */
/*
  Self-checking bench for apmc_core with shortened rate and wake counts.
  Assumes apmc_host_model drives the byte port at falling edges.
*/
`timescale 1ns/1ps
module test_accel_power_mode_control
  import apmc_pkg::*;
;
  localparam int FP = 8;
  localparam int WX = 20;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic inactive = 1'b0;
  apmc_req_t req;
  logic [7:0] reg_rdata_r;
  logic reg_rvalid_r;
  logic [7:0] inact_thresh_r;
  logic [7:0] inact_time_r;
  logic sample_tick;
  logic first_data_r;
  apmc_status_t status_r;
  int fails = 0;
  int n_compared = 0;
  int ticks = 0;
  int n;
  int p;
  int t0;
  logic [7:0] v;

  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) if (sample_tick === 1'b1) ticks++;

  apmc_core #(.FAST_PERIOD_CYC(FP), .WAKE_EXTRA_CYC(WX)) dut_u (
    .core_clk(core_clk), .rst(rst), .req(req), .reg_rdata_r(reg_rdata_r),
    .reg_rvalid_r(reg_rvalid_r), .inactive(inactive), .inact_thresh_r(inact_thresh_r),
    .inact_time_r(inact_time_r), .sample_tick(sample_tick), .first_data_r(first_data_r),
    .status_r(status_r));
  apmc_host_model host_u (.core_clk(core_clk), .req(req), .reg_rdata_r(reg_rdata_r),
    .reg_rvalid_r(reg_rvalid_r));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
      fails++;
    end
  endtask

  task automatic rd(input string what, input logic [5:0] a, input logic [7:0] exp);
    host_u.read_byte(a, v);
    chk(what, 16'(v), 16'(exp));
  endtask

  task automatic wt(input int k);
    repeat (k) @(negedge core_clk);
  endtask

  // Counts falling edges until the next tick; bounded so a stall cannot hang
  task automatic next_tick(output int k);
    k = 0;
    do
    begin
      @(negedge core_clk);
      k++;
    end
    while (sample_tick !== 1'b1 && k < 9000);
  endtask

  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #(60000 * 20);
    fails++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    wt(10);
    rst <= 1'b0;
    wt(1);
    // Standby status still reports the selected rate code
    chk("status", 16'(status_r), 16'(APMC_RST_DATA_RATE[3:0]));
    rd("thresh", APMC_ADDR_INACT_THRESH, 8'h00);
    rd("time", APMC_ADDR_INACT_TIME, 8'h00);
    rd("rate", APMC_ADDR_DATA_RATE, 8'h0A);
    rd("power", APMC_ADDR_POWER, 8'h00);
    host_u.write_byte(6'h3F, 8'h5A);
    rd("unmapped", 6'h3F, 8'h00);
    chk("no_ticks", 16'(ticks), 16'h0000);
    $display("test reset done");
    // Rate codes walked from fastest to slowest, each from standby
    for (int c = 15; c >= 6; c--)
    begin
      p = FP << (15 - c);
      host_u.write_byte(APMC_ADDR_DATA_RATE, 8'(c));
      host_u.write_byte(APMC_ADDR_POWER, 8'h08);
      n = 0;
      while (status_r.waking !== 1'b1 && n < 4)
      begin
        @(negedge core_clk);
        n++;
      end
      n = 0;
      while (first_data_r !== 1'b1 && n < 9000)
      begin
        @(negedge core_clk);
        n++;
      end
      // Count also takes the cycle that leaves wake
      chk("wake_cycles", 16'(n), 16'(p + WX + 1));
      chk("measuring", 16'(status_r.measuring), 16'h0001);
      chk("eff_rate", 16'(status_r.eff_rate), 16'(c));
      next_tick(n);
      next_tick(n);
      chk("tick_period", 16'(n), 16'(p));
      host_u.write_byte(APMC_ADDR_POWER, 8'h00);
      wt(2);
      chk("standby", 16'(status_r), 16'(c));
      t0 = ticks;
      wt(40);
      chk("standby_ticks", 16'(ticks - t0), 16'h0000);
    end
    $display("test rates done");
    host_u.write_byte(APMC_ADDR_INACT_THRESH, 8'h10);
    host_u.write_byte(APMC_ADDR_INACT_TIME, 8'h04);
    rd("thresh", APMC_ADDR_INACT_THRESH, 8'h10);
    chk("time_out", 16'(inact_time_r), 16'h0004);
    chk("thresh_out", 16'(inact_thresh_r), 16'h0010);
    host_u.write_byte(APMC_ADDR_DATA_RATE, 8'h1C);
    rd("rate_lp", APMC_ADDR_DATA_RATE, 8'h1C);
    host_u.write_byte(APMC_ADDR_POWER, 8'h08);
    wt(FP * 8 + WX + 8);
    chk("low_power", 16'(status_r.low_power_active), 16'h0001);
    host_u.write_byte(APMC_ADDR_DATA_RATE, 8'h0C);
    wt(2);
    chk("low_power_off", 16'(status_r.low_power_active), 16'h0000);
    $display("test low power done");
    host_u.write_byte(APMC_ADDR_POWER, 8'h38);
    inactive <= 1'b1;
    wt(3);
    chk("asleep", 16'(status_r.asleep), 16'h0001);
    chk("sleep_rate", 16'(status_r.eff_rate), 16'(APMC_RATE_SLEEP));
    inactive <= 1'b0;
    wt(3);
    chk("rewake", 16'(status_r.waking), 16'h0001);
    host_u.write_byte(APMC_ADDR_POWER, 8'h00);
    wt(2);
    chk("standby", 16'(status_r), 16'h000C);
    rd("thresh_kept", APMC_ADDR_INACT_THRESH, 8'h10);
    $display("test sleep done");
    conclude();
  end
endmodule
